// ==== rtl/twm_master_tx.sv ====
// two-wire master transmitter with apb registers and transmit fifo
// Summary of operation
// [RL1] master alone starts each transfer, drives clock, ends with stop
// [RL2] software sets address, divisors, slave disable, then master enable
// [RL3] target address may be rewritten while master mode stays enabled
// [RL4] holding register write starts transfer: start then 7-bit address
// [RL5] direction bit after address equals read select, zero for transmit
// [RL6] ninth clock pulse: data line released so slave can acknowledge
// [RL7] missing acknowledge sets nack flag and sends a stop condition
// [RL8] nack flag clears on status read, before next holding write
// [RL9] each status bit raises interrupt when its enable bit is set
// [RL10] on acknowledge the next held byte moves to shifter and is sent
// [RL11] acknowledge sets transmit ready, kept until next holding write
// [RL12] transmit ready doubles as dma transmit channel request
// [RL13] with no new byte the serial clock is held low
// [RL14] new byte written releases the serial clock and is sent
// [RL15] writing one to stop bit of control generates a stop
// [RL16] high and low clock phases follow divisors and prescaler
// [RL17] stop request waits for current byte and acknowledge to finish
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "twm_consts.svh"

// small synchronous fifo, power of two depth
module twm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic push;
	logic pop;

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
			$error("fifo depth must be a power of two, at least 2");
		end
	endgenerate

	// full when pointers differ only in the wrap bit
	assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data = mem[rd_ptr[AW-1:0]];
	assign push = ce & in_valid & in_ready;
	assign pop = ce & out_valid & out_ready;

	// storage has no reset, contents are qualified by the pointers
	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	// pointers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule

module twm_master_tx import twm_pkg::*; #(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic dma_tx_req,
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);
	twm_state_t state;
	logic master_mode_enable;
	logic slave_mode_disable;
	logic stop_pend;
	logic [6:0] target_device_address;
	logic read_direction_select;
	logic [7:0] clock_low_divisor;
	logic [7:0] clock_high_divisor;
	logic [2:0] clock_prescale_divisor;
	logic transmit_ready_flag;
	logic nack;
	logic [31:0] int_mask;
	logic [8:0] shift;
	logic [3:0] bit_cnt;
	logic [19:0] timer;
	logic scl_meta;
	logic scl_sync;
	logic sda_meta;
	logic sda_sync;
	logic acc;
	logic done;
	logic thr_wr;
	logic mapped;
	logic fifo_in_ready;
	logic fifo_valid;
	logic fifo_pop;
	logic [7:0] fifo_data;
	logic [31:0] status;
	logic [31:0] rd_val;
	logic [19:0] len_low;
	logic [19:0] len_high;

	generate
		if (FIFO_DEPTH < 2) begin : g_bad_fifo
			$error("FIFO_DEPTH must be at least 2");
		end
	endgenerate

	// phase length in pclk cycles: (divisor + 1) << prescaler
	function automatic logic [19:0] phase_len(input logic [7:0] div,
		input logic [2:0] presc);
		phase_len = ({12'h000, div} + 20'h00001) << presc;
	endfunction

	// decode of mapped offsets, used by the pslverr answer only; the read mux decodes paddr itself
	function automatic logic is_mapped(input logic [11:0] a);
		case (a)
			`TWM_OFS_CONTROL_COMMAND,
			`TWM_OFS_MASTER_MODE_CONFIG,
			`TWM_OFS_CLOCK_WAVEFORM_CONFIG,
			`TWM_OFS_STATUS_REGISTER,
			`TWM_OFS_INTERRUPT_ENABLE_SET,
			`TWM_OFS_INTERRUPT_DISABLE,
			`TWM_OFS_INTERRUPT_MASK,
			`TWM_OFS_TRANSMIT_HOLDING: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	assign len_low = phase_len(clock_low_divisor, clock_prescale_divisor); // [RL16]
	assign len_high = phase_len(clock_high_divisor, clock_prescale_divisor); // [RL16]
	assign acc = psel & penable;
	assign done = ce & acc & pready;
	assign mapped = is_mapped(paddr);
	assign thr_wr = pwrite & (paddr == `TWM_OFS_TRANSMIT_HOLDING);
	assign dma_tx_req = transmit_ready_flag; // [RL12]
	assign sda_out = 1'b0;
	assign serial_clock_pin_out = 1'b0;

	always_comb begin
		status = 32'h0000_0000;
		status[`TWM_SR_IDLE] = (state == TWM_IDLE);
		status[`TWM_SR_TRANSMIT_READY_FLAG] = transmit_ready_flag;
		status[`TWM_SR_NACK] = nack;
	end

	always_comb begin
		case (paddr)
			`TWM_OFS_MASTER_MODE_CONFIG: begin
				rd_val = 32'h0000_0000;
				rd_val[`TWM_MMR_ADDR_LSB +: 7] = target_device_address;
				rd_val[`TWM_MMR_READ_DIR] = read_direction_select;
			end
			`TWM_OFS_CLOCK_WAVEFORM_CONFIG: begin
				rd_val = 32'h0000_0000;
				rd_val[`TWM_CWG_LOW_LSB +: 8] = clock_low_divisor;
				rd_val[`TWM_CWG_HIGH_LSB +: 8] = clock_high_divisor;
				rd_val[`TWM_CWG_PRESC_LSB +: 3] = clock_prescale_divisor;
			end
			`TWM_OFS_STATUS_REGISTER: rd_val = status;
			`TWM_OFS_INTERRUPT_MASK: rd_val = int_mask;
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// one wait state; a holding write waits further while the fifo is full
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			pready <= acc & !pready & !(thr_wr & !fifo_in_ready);
			pslverr <= acc & !pready & !mapped;
			prdata <= (acc & !pready & !pwrite) ? rd_val : 32'h0000_0000;
		end
	end

	// configuration registers written by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			target_device_address <= 7'h00;
			read_direction_select <= 1'b0;
			// reset divisors cut from the packed reset word
			clock_low_divisor <= 8'(`TWM_RST_CWG >> `TWM_CWG_LOW_LSB);
			clock_high_divisor <= 8'(`TWM_RST_CWG >> `TWM_CWG_HIGH_LSB);
			clock_prescale_divisor <= 3'(`TWM_RST_CWG >> `TWM_CWG_PRESC_LSB);
			int_mask <= 32'h0000_0000;
		end else if (done && pwrite) begin
			case (paddr)
				`TWM_OFS_MASTER_MODE_CONFIG: begin
					// no gating by master enable [RL3]
					target_device_address <= pwdata[`TWM_MMR_ADDR_LSB +: 7];
					read_direction_select <= pwdata[`TWM_MMR_READ_DIR];
				end
				`TWM_OFS_CLOCK_WAVEFORM_CONFIG: begin
					clock_low_divisor <= pwdata[`TWM_CWG_LOW_LSB +: 8];
					clock_high_divisor <= pwdata[`TWM_CWG_HIGH_LSB +: 8];
					clock_prescale_divisor <= pwdata[`TWM_CWG_PRESC_LSB +: 3];
				end
				`TWM_OFS_INTERRUPT_ENABLE_SET:
					int_mask <= int_mask | (pwdata & `TWM_SR_MASK);
				`TWM_OFS_INTERRUPT_DISABLE:
					int_mask <= int_mask & ~pwdata;
				default: ;
			endcase
		end
	end

	// mode bits from the control command register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			master_mode_enable <= 1'b0;
			slave_mode_disable <= 1'b0;
		end else if (done && pwrite &&
			paddr == `TWM_OFS_CONTROL_COMMAND) begin
			if (pwdata[`TWM_CMD_SLAVE_DISABLE]) begin
				slave_mode_disable <= 1'b1;
			end
			// disable wins when both are written together
			if (pwdata[`TWM_CMD_MASTER_DISABLE]) begin
				master_mode_enable <= 1'b0;
			end else if (pwdata[`TWM_CMD_MASTER_ENABLE]) begin
				master_mode_enable <= 1'b1;
			end
		end
	end

	// status flags: hardware set wins over a same-cycle clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nack <= 1'b0;
			transmit_ready_flag <= 1'b1;
		end else if (ce) begin
			if (state == TWM_ACK_HIGH && timer == 20'h0 && scl_sync &&
				sda_sync) begin
				nack <= 1'b1; // [RL7]
			end else if (done && !pwrite &&
				paddr == `TWM_OFS_STATUS_REGISTER) begin
				nack <= 1'b0; // [RL8]
			end
			if (state == TWM_ACK_HIGH && timer == 20'h0 && scl_sync &&
				!sda_sync) begin
				transmit_ready_flag <= 1'b1; // [RL11]
			end else if (done && thr_wr) begin
				transmit_ready_flag <= 1'b0; // [RL11]
			end
		end
	end

	// interrupt line registered so the output stays glitch free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(status & int_mask); // [RL9]
		end
	end

	// two-flop synchronisers for the open-drain lines
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_meta <= 1'b1;
			scl_sync <= 1'b1;
			sda_meta <= 1'b1;
			sda_sync <= 1'b1;
		end else if (ce) begin
			scl_meta <= serial_clock_pin_in;
			scl_sync <= scl_meta;
			sda_meta <= sda_in;
			sda_sync <= sda_meta;
		end
	end

	twm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.in_valid(done & thr_wr),
		.in_ready(fifo_in_ready),
		.in_data(pwdata[7:0]),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	// a byte leaves the fifo after an ack or from hold; opening a frame pops nothing
	assign fifo_pop = ce && timer == 20'h0 && (
		(state == TWM_ACK_HIGH && scl_sync && !sda_sync && !stop_pend) ||
		(state == TWM_HOLD && !stop_pend));

	// stop request is latched and served at a byte boundary [RL17]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_pend <= 1'b0;
		end else if (ce) begin
			if (done && pwrite && paddr == `TWM_OFS_CONTROL_COMMAND &&
				pwdata[`TWM_CMD_STOP]) begin
				stop_pend <= 1'b1; // [RL15]
			end else if (state == TWM_STOP_LOW || state == TWM_IDLE) begin
				stop_pend <= 1'b0;
			end
		end
	end

	// bus sequencer; high phases count only once scl reads high,
	// so a slave stretching the clock just lengthens them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= TWM_IDLE;
			timer <= 20'h0;
			shift <= 9'h000;
			bit_cnt <= 4'h0;
			serial_clock_pin_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else if (ce) begin
			if (timer != 20'h0 && (scl_sync || serial_clock_pin_oe)) begin
				timer <= timer - 20'h1;
			end
			case (state)
				TWM_IDLE: begin
					serial_clock_pin_oe <= 1'b0;
					sda_oe <= 1'b0;
					if (master_mode_enable && fifo_valid) begin
						sda_oe <= 1'b1; // start: sda falls, scl high [RL1] [RL4]
						timer <= len_high;
						state <= TWM_START;
					end
				end
				TWM_START: begin
					if (timer == 20'h0) begin
						// address then direction bit [RL4] [RL5]
						shift <= {target_device_address,
							read_direction_select, 1'b0};
						bit_cnt <= `TWM_BITS_PER_BYTE;
						serial_clock_pin_oe <= 1'b1; // [RL1]
						timer <= len_low;
						state <= TWM_BIT_LOW;
					end
				end
				TWM_BIT_LOW: begin
					sda_oe <= !shift[8];
					if (timer == 20'h0) begin
						serial_clock_pin_oe <= 1'b0;
						timer <= len_high;
						state <= TWM_BIT_HIGH;
					end
				end
				TWM_BIT_HIGH: begin
					if (timer == 20'h0 && scl_sync) begin
						serial_clock_pin_oe <= 1'b1;
						shift <= {shift[7:0], 1'b0};
						bit_cnt <= bit_cnt - 4'h1;
						timer <= len_low;
						state <= (bit_cnt == 4'h1) ? TWM_ACK_LOW : TWM_BIT_LOW;
					end
				end
				TWM_ACK_LOW: begin
					sda_oe <= 1'b0; // release for the ninth pulse [RL6]
					if (timer == 20'h0) begin
						serial_clock_pin_oe <= 1'b0;
						timer <= len_high;
						state <= TWM_ACK_HIGH;
					end
				end
				TWM_ACK_HIGH: begin
					if (timer == 20'h0 && scl_sync) begin
						serial_clock_pin_oe <= 1'b1;
						timer <= len_low;
						if (sda_sync || stop_pend) begin
							state <= TWM_STOP_LOW; // [RL7] [RL17]
						end else if (fifo_valid) begin
							shift <= {fifo_data, 1'b0}; // [RL10]
							bit_cnt <= `TWM_BITS_PER_BYTE;
							state <= TWM_BIT_LOW;
						end else begin
							state <= TWM_HOLD;
						end
					end
				end
				TWM_HOLD: begin
					serial_clock_pin_oe <= 1'b1; // stretch the bus [RL13]
					if (timer == 20'h0) begin
						// fresh low phase, so sda settles before scl rises
						if (stop_pend) begin
							timer <= len_low;
							state <= TWM_STOP_LOW;
						end else if (fifo_valid) begin
							timer <= len_low;
							shift <= {fifo_data, 1'b0}; // [RL14]
							bit_cnt <= `TWM_BITS_PER_BYTE;
							state <= TWM_BIT_LOW;
						end
					end
				end
				TWM_STOP_LOW: begin
					sda_oe <= 1'b1;
					if (timer == 20'h0) begin
						serial_clock_pin_oe <= 1'b0;
						timer <= len_high;
						state <= TWM_STOP_HIGH;
					end
				end
				TWM_STOP_HIGH: begin
					if (timer == 20'h0 && scl_sync) begin
						sda_oe <= 1'b0; // sda rises with scl high [RL1]
						timer <= len_high;
						state <= TWM_STOP_REL;
					end
				end
				TWM_STOP_REL: begin
					// bus free time before the next start
					if (timer == 20'h0) begin
						state <= TWM_IDLE;
					end
				end
				default: begin
					state <= TWM_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== rtl/twm_consts.svh ====
// register map, field positions, reset values and timing constants
`ifndef TWM_CONSTS_SVH
`define TWM_CONSTS_SVH
`define TWM_OFS_CONTROL_COMMAND 12'h000
`define TWM_OFS_MASTER_MODE_CONFIG 12'h004
`define TWM_OFS_CLOCK_WAVEFORM_CONFIG 12'h010
`define TWM_OFS_STATUS_REGISTER 12'h020
`define TWM_OFS_INTERRUPT_ENABLE_SET 12'h024
`define TWM_OFS_INTERRUPT_DISABLE 12'h028
`define TWM_OFS_INTERRUPT_MASK 12'h02C
`define TWM_OFS_TRANSMIT_HOLDING 12'h034
`define TWM_CMD_MASTER_ENABLE 0
`define TWM_CMD_MASTER_DISABLE 1
`define TWM_CMD_SLAVE_DISABLE 2
`define TWM_CMD_STOP 3
`define TWM_MMR_READ_DIR 12
`define TWM_MMR_ADDR_LSB 16
`define TWM_CWG_LOW_LSB 0
`define TWM_CWG_HIGH_LSB 8
`define TWM_CWG_PRESC_LSB 16
`define TWM_SR_IDLE 0
`define TWM_SR_TRANSMIT_READY_FLAG 2
`define TWM_SR_NACK 8
`define TWM_SR_MASK 32'h0000_0105
`define TWM_RST_CWG 32'h0000_0F0F
`define TWM_BITS_PER_BYTE 4'h8
`endif

// ==== rtl/twm_pkg.sv ====
// types shared by the two-wire master transmitter
package twm_pkg;
	typedef enum logic [3:0] {
		TWM_IDLE = 4'h0,
		TWM_START = 4'h1,
		TWM_BIT_LOW = 4'h3,
		TWM_BIT_HIGH = 4'h2,
		TWM_ACK_LOW = 4'h6,
		TWM_ACK_HIGH = 4'h7,
		TWM_HOLD = 4'h5,
		TWM_STOP_LOW = 4'h4,
		TWM_STOP_HIGH = 4'hC,
		TWM_STOP_REL = 4'hD
	} twm_state_t;
endpackage

// ==== sim/twm_master_tx_monitor.sv ====
// assertion checker on the two-wire master transmitter ports
`timescale 1ns/1ps
`default_nettype none
`include "twm_consts.svh"
module twm_master_tx_monitor #(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic dma_tx_req,
	input wire logic serial_clock_pin_in,
	input wire logic serial_clock_pin_out,
	input wire logic serial_clock_pin_oe,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe
);
	logic q_scl, q_sda, addr_byte, wr, mapped, hi2;
	logic [3:0] pulse;
	logic [9:0] lo_cnt, lo_len;
	logic [6:0] adr;
	assign wr = psel && penable && pready && pwrite;
	assign mapped = paddr inside {12'h000, 12'h004, 12'h010, 12'h020,
		12'h024, 12'h028, 12'h02C, 12'h034};
	// second and later cycles of a released clock phase
	assign hi2 = !serial_clock_pin_oe && !q_scl;
	// previous enables, for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_scl <= 1'b0;
			q_sda <= 1'b0;
		end else begin
			q_scl <= serial_clock_pin_oe;
			q_sda <= sda_oe;
		end
	end
	// pulse number in the byte; a start resets it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse <= 4'h0;
			addr_byte <= 1'b0;
		end else if (sda_oe && !q_sda && !serial_clock_pin_oe) begin
			pulse <= 4'h0;
			addr_byte <= 1'b1;
		end else if (!serial_clock_pin_oe && q_scl) begin
			pulse <= (pulse == 4'h9) ? 4'h1 : pulse + 4'h1;
			addr_byte <= addr_byte && (pulse != 4'h9);
		end
	end
	// low phase length, saturating so a long hold cannot wrap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lo_cnt <= 10'h000;
		end else if (!serial_clock_pin_oe) begin
			lo_cnt <= 10'h000;
		end else if (lo_cnt != 10'h3FF) begin
			lo_cnt <= lo_cnt + 10'h001;
		end
	end
	// shadow of low phase length (low divisor, prescaler) and target address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lo_len <= 10'h010;
			adr <= 7'h00;
		end else if (wr && paddr == `TWM_OFS_CLOCK_WAVEFORM_CONFIG) begin
			lo_len <= ({2'h0, pwdata[7:0]} + 10'h001) << pwdata[18:16];
		end else if (wr && paddr == `TWM_OFS_MASTER_MODE_CONFIG) begin
			adr <= pwdata[22:16];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_start;
		$rose(sda_oe) && !serial_clock_pin_oe;
	endsequence
	sequence s_first_low;
		sda_oe throughout (##[1:1000] serial_clock_pin_oe);
	endsequence
	sequence s_ack_end;
		serial_clock_pin_oe && !q_scl && pulse == 4'h9;
	endsequence
	sequence s_stop;
		##[1:1000] ($fell(sda_oe) && !serial_clock_pin_oe);
	endsequence
	property p_start;
		s_start |-> s_first_low;
	endproperty
	a_start: assert property (p_start) else $error("bad start");
	property p_addr;
		hi2 && addr_byte && pulse inside {[1:7]} |->
			sda_oe == !adr[4'h7 - pulse];
	endproperty
	a_addr: assert property (p_addr) else $error("bad address");
	property p_dir;
		hi2 && addr_byte && pulse == 4'h8 |-> sda_oe;
	endproperty
	a_dir: assert property (p_dir) else $error("bad direction");
	property p_ack_rel;
		hi2 && pulse == 4'h9 |-> !sda_oe;
	endproperty
	a_ack_rel: assert property (p_ack_rel) else $error("sda held");
	property p_nack_stop;
		s_ack_end and $past(sda_in) |-> s_stop;
	endproperty
	a_nack_stop: assert property (p_nack_stop) else $error("no stop");
	property p_ack_rdy;
		s_ack_end and !$past(sda_in) |-> ##[0:8] dma_tx_req;
	endproperty
	a_ack_rdy: assert property (p_ack_rdy) else $error("no ready");
	property p_thr_clr;
		wr && paddr == `TWM_OFS_TRANSMIT_HOLDING &&
			!(hi2 && pulse == 4'h9) |=> !dma_tx_req;
	endproperty
	a_thr_clr: assert property (p_thr_clr) else $error("ready kept");
	property p_stop_req;
		wr && paddr == `TWM_OFS_CONTROL_COMMAND && pwdata[3] &&
			serial_clock_pin_oe |-> s_stop;
	endproperty
	a_stop_req: assert property (p_stop_req) else $error("stop lost");
	property p_low;
		!serial_clock_pin_oe && q_scl |-> lo_cnt >= lo_len;
	endproperty
	a_low: assert property (p_low) else $error("low too short");
	property p_slverr;
		pready && !mapped |-> pslverr;
	endproperty
	a_slverr: assert property (p_slverr) else $error("no slverr");
endmodule
bind twm_master_tx twm_master_tx_monitor #(.FIFO_DEPTH(FIFO_DEPTH))
	twm_master_tx_monitor_i (.pclk(pclk), .presetn(presetn), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.irq(irq), .dma_tx_req(dma_tx_req),
	.serial_clock_pin_in(serial_clock_pin_in),
	.serial_clock_pin_out(serial_clock_pin_out),
	.serial_clock_pin_oe(serial_clock_pin_oe), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// ==== sim/twm_slave_model.sv ====
// behavioural two-wire slave: acknowledges, records bytes, may stretch
`timescale 1ns/1ps
`default_nettype none
module twm_slave_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic [3:0] nack_at,
	input wire logic slow,
	output logic scl_drv,
	output logic sda_drv
);
	logic [7:0] sh;
	logic [7:0] got [$];
	int cnt = 0;
	int idx = 0;
	int stops = 0;
	bit busy = 1'b0;
	// both lines released until there is something to answer
	initial begin
		scl_drv = 1'b1;
		sda_drv = 1'b1;
	end
	// start: data falls while clock high
	always @(negedge sda) if (scl === 1'b1) begin
		cnt = 0;
		idx = 0;
		busy = 1'b1;
	end
	// stop: data rises while clock high; only after a start, so the
	// lines leaving unknown at power-up are not taken for a stop
	always @(posedge sda) if (scl === 1'b1 && busy) begin
		stops++;
		busy = 1'b0;
	end
	// bits taken on the rising clock, first bit is the msb
	always @(posedge scl) if (cnt < 8) begin
		sh = {sh[6:0], sda};
		cnt++;
	end else cnt = 9;
	// ack slot answered on the falling clock
	always @(negedge scl) begin
		if (cnt == 8) begin
			got.push_back(sh);
			sda_drv = (idx == nack_at);
			idx++;
		end else if (cnt == 9) begin
			sda_drv = 1'b1;
			cnt = 0;
		end
		// a slow slave keeps the clock low a while longer
		if (slow) begin
			scl_drv = 1'b0;
			#200 scl_drv = 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench for the two-wire master transmitter
`timescale 1ns/1ps
`default_nettype none
`include "twm_consts.svh"
module testbench;
	localparam logic [11:0] o_ctl = `TWM_OFS_CONTROL_COMMAND;
	localparam logic [11:0] o_mmr = `TWM_OFS_MASTER_MODE_CONFIG;
	localparam logic [11:0] o_cwg = `TWM_OFS_CLOCK_WAVEFORM_CONFIG;
	localparam logic [11:0] o_sr = `TWM_OFS_STATUS_REGISTER;
	localparam logic [11:0] o_thr = `TWM_OFS_TRANSMIT_HOLDING;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic slow = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] nack_at = 4'hF;
	logic [31:0] prdata, q;
	logic pready, pslverr, irq, dma_tx_req, err;
	logic scl_out, scl_oe, sda_out, sda_oe, scl_drv, sda_drv, scl_w, sda_w;
	int err_count = 0;
	int num_checks = 0;
	always #10 pclk = ~pclk;
	// open-drain wires with pull-ups
	assign scl_w = scl_oe ? scl_out : scl_drv;
	assign sda_w = sda_oe ? sda_out : sda_drv;
	twm_master_tx twm_master_tx_i (.pclk(pclk), .presetn(presetn),
		.ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .dma_tx_req(dma_tx_req),
		.serial_clock_pin_in(scl_w), .serial_clock_pin_out(scl_out),
		.serial_clock_pin_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe(sda_oe));
	twm_slave_model twm_slave_model_i (.scl(scl_w), .sda(sda_w),
		.nack_at(nack_at), .slow(slow), .scl_drv(scl_drv),
		.sda_drv(sda_drv));
	task automatic tally_and_finish();
		if (err_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// one apb transfer; waits for pready, bounded
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 800) begin
			@(posedge pclk);
			n++;
		end
		chk("pready", 32'h1, pready);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_stop(input int k);
		int n;
		n = 0;
		while (twm_slave_model_i.stops < k && n < 4000) begin
			@(posedge pclk);
			n++;
		end
		chk("stops", k, twm_slave_model_i.stops);
	endtask
	task automatic rx(input logic [7:0] e);
		logic [7:0] g;
		if (twm_slave_model_i.got.size() > 0)
			g = twm_slave_model_i.got.pop_front();
		chk("byte", {24'h0, e}, {24'h0, g});
	endtask
	// wait for nb bytes, check the clock is held, then request a stop
	task automatic finish_frame(input int nb, input int k);
		int n;
		n = 0;
		while (twm_slave_model_i.got.size() < nb && n < 4000) begin
			@(posedge pclk);
			n++;
		end
		repeat (60) @(posedge pclk);
		chk("scl held", 32'h0, scl_w);
		chk("dma_tx_req", 32'h1, dma_tx_req);
		apb(1'b1, o_ctl, 32'h8);
		wait_stop(k);
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("dma_tx_req", 32'h1, dma_tx_req);
		apb(1'b0, o_cwg, 32'h0);
		chk("cwg", `TWM_RST_CWG, q);
		apb(1'b0, 12'h0FC, 32'h0);
		chk("slverr", 32'h1, err);
		apb(1'b1, o_mmr, 32'h002B_0000);
		apb(1'b1, o_cwg, 32'h0000_0103);
		apb(1'b1, o_ctl, 32'h4);
		apb(1'b1, o_ctl, 32'h1);
		apb(1'b1, o_thr, 32'hA5);
		chk("dma_tx_req", 32'h0, dma_tx_req);
		apb(1'b1, o_thr, 32'h3C);
		finish_frame(3, 1);
		rx(8'h56);
		rx(8'hA5);
		rx(8'h3C);
		// new target while master mode stays on
		apb(1'b1, o_mmr, 32'h0011_0000);
		apb(1'b1, o_thr, 32'h81);
		finish_frame(2, 2);
		rx(8'h22);
		rx(8'h81);
		// data byte refused by the slave
		nack_at <= 4'h1;
		apb(1'b1, `TWM_OFS_INTERRUPT_ENABLE_SET, 32'h100);
		apb(1'b0, `TWM_OFS_INTERRUPT_MASK, 32'h0);
		chk("mask", 32'h100, q);
		apb(1'b1, o_thr, 32'h77);
		wait_stop(3);
		rx(8'h22);
		rx(8'h77);
		chk("irq", 32'h1, irq);
		// disable while nack still stands; irq lags the mask by a cycle
		apb(1'b1, `TWM_OFS_INTERRUPT_DISABLE, 32'h100);
		@(posedge pclk);
		chk("irq", 32'h0, irq);
		apb(1'b0, o_sr, 32'h0);
		chk("nack", 32'h1, q[`TWM_SR_NACK]);
		apb(1'b0, o_sr, 32'h0);
		chk("nack", 32'h0, q[`TWM_SR_NACK]);
		// fill the fifo past its depth against a stretching slave
		nack_at <= 4'hF;
		slow <= 1'b1;
		for (int i = 1; i <= 5; i++) begin
			apb(1'b1, o_thr, i);
		end
		finish_frame(6, 4);
		rx(8'h22);
		for (int i = 1; i <= 5; i++) begin
			rx(i[7:0]);
		end
		// master disabled: a held byte must not open a frame
		apb(1'b1, o_ctl, 32'h2);
		apb(1'b1, o_thr, 32'h99);
		repeat (100) @(posedge pclk);
		chk("idle sda", 32'h1, sda_w);
		chk("stops", 32'h4, twm_slave_model_i.stops);
		apb(1'b0, o_mmr, 32'h0);
		chk("mmr", 32'h0011_0000, q);
		tally_and_finish();
	end
	// watchdog: the whole sequence needs well under this
	initial begin
		#1000000;
		err_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
